/* rtl/bmc_top.sv */
module bmc_top import bmc_pkg::*; #(
   parameter bit AUTO_VARIANT = 1'b1,
   parameter int NO_LOAD_COUNT = NO_LOAD_CYCLES
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOeN,
   input wire logic addrSelect,
   input wire logic triggerIn,
   input wire bmc_sense_s sense,
   output bmc_drive_s drive,
   output logic readyOut,
   output logic [7:0] outputSetpoint,
   output logic [7:0] chargeCurrent,
   output logic [7:0] profileHigh,
   output logic [7:0] modeCommand,
   output logic autoModeOn
);
   logic [3:0] pinMeta;
   logic [3:0] pinSync;
   bmc_sense_s senseMeta;
   bmc_sense_s senseSync;
   logic sclLast;
   logic sdaLast;
   logic trigLast;
   logic sclSync;
   logic sdaSync;
   logic adrSync;
   logic trigSync;
   logic sclRise;
   logic sclFall;
   logic startSeen;
   logic stopSeen;
   logic trigRise;
   bmc_state_e state;
   bmc_state_e next_state;
   bmc_i2c_e iState;
   logic [7:0] setupThree;
   logic [7:0] status;
   logic [7:0] readByte;
   logic [7:0] memQ;
   logic [7:0] shift;
   logic [7:0] ptr;
   logic [2:0] bitCnt;
   logic firstByte;
   logic ackPhase;
   logic readMode;
   logic loadNow;
   logic regWrite;
   logic [7:0] wAddr;
   logic [7:0] wData;
   logic [6:0] myAddr;
   logic autoCycle;
   logic autoLong;
   logic autoEnd;
   logic [15:0] nlCount;
   logic anyMode;

   // Every pin and comparator input crosses through two flops first.
   always_ff @(posedge clock) begin
      if (reset) begin
         pinMeta <= 4'hc; // Idle levels: bus lines high, select and trigger low.
         pinSync <= 4'hc; // Matching idle levels keeps a false trigger edge out.
         senseMeta <= '0;
         senseSync <= '0;
      end else begin
         pinMeta <= {sclIn, sdaIn, addrSelect, triggerIn};
         pinSync <= pinMeta;
         senseMeta <= sense;
         senseSync <= senseMeta;
      end
   end

   assign sclSync = pinSync[3];
   assign sdaSync = pinSync[2];
   assign adrSync = pinSync[1];
   assign trigSync = pinSync[0];

   // Previous samples for edge detection on the synchronised copies.
   always_ff @(posedge clock) begin
      if (reset) begin
         sclLast <= 1'b1;
         sdaLast <= 1'b1;
         trigLast <= 1'b0;
      end else begin
         sclLast <= sclSync;
         sdaLast <= sdaSync;
         trigLast <= trigSync;
      end
   end

   // Bus conditions; start and stop are data edges while the clock is high.
   assign sclRise = sclSync & ~sclLast;
   assign sclFall = ~sclSync & sclLast;
   assign startSeen = sclSync & sclLast & sdaLast & ~sdaSync;
   assign stopSeen = sclSync & sclLast & ~sdaLast & sdaSync;
   assign trigRise = trigSync & ~trigLast;
   assign myAddr = adrSync ? SLAVE_ADDR_HIGH : SLAVE_ADDR_LOW;
   assign anyMode = modeCommand[CMD_ON_DEMAND] | modeCommand[CMD_CONTINUOUS]
                  | modeCommand[CMD_FORCE_DRIVE];

   // Operating state selection; no transition needs standby first.
   always_comb begin
      next_state = state;
      if (!anyMode) begin
         next_state = ST_STANDBY;
      end else if (modeCommand[CMD_FORCE_DRIVE]) begin
         next_state = ST_ACTIVE;
      end else begin
         unique case (state)
            ST_STANDBY: next_state = ST_CHARGE;
            ST_CHARGE: begin
               if (senseSync.capAtTarget) begin
                  next_state = modeCommand[CMD_CONTINUOUS] ? ST_CAP_FULL : ST_ACTIVE;
               end
            end
            ST_CAP_FULL: begin
               if (!modeCommand[CMD_CONTINUOUS]) begin
                  next_state = ST_ACTIVE;
               end else if (senseSync.capBelowTarget) begin
                  next_state = ST_CHARGE;
               end
            end
            ST_ACTIVE: begin
               if (modeCommand[CMD_CONTINUOUS]) begin
                  next_state = ST_CHARGE;
               end
            end
         endcase
      end
   end

   // State register and the drive word; its fields share one process so the
   // struct port has a single driver.
   always_ff @(posedge clock) begin
      if (reset) begin
         state <= ST_STANDBY;
         drive.chargeEnable <= 1'b0;
         drive.driveEnable <= 1'b0;
         drive.optClear <= 1'b0;
      end else begin
         state <= next_state;
         drive.chargeEnable <= next_state == ST_CHARGE;
         drive.driveEnable <= next_state == ST_ACTIVE;
         // The clear bit is a strobe only; zero writes do nothing.
         drive.optClear <= regWrite && wAddr == REG_MODE_COMMAND && wData[CMD_OPT_CLEAR];
      end
   end

   // Ready: capacitor full in continuous idle, or output regulating while active.
   always_ff @(posedge clock) begin
      if (reset) begin
         readyOut <= 1'b0;
      end else begin
         readyOut <= next_state == ST_CAP_FULL
                  || (next_state == ST_ACTIVE && senseSync.outputRegulating);
      end
   end

   // Mode command register; a trigger set wins over any clear this cycle.
   always_ff @(posedge clock) begin
      if (reset) begin
         modeCommand <= CMD_RESET;
      end else begin
         if (regWrite && wAddr == REG_MODE_COMMAND) begin
            modeCommand <= wData & ~(8'h01 << CMD_OPT_CLEAR);
         end
         if (autoEnd) begin
            modeCommand[CMD_ON_DEMAND] <= 1'b0;
         end
         if (autoModeOn && trigRise) begin
            modeCommand[CMD_ON_DEMAND] <= 1'b1;
         end
      end
   end

   // Setup registers held in flops because the core logic reads them.
   always_ff @(posedge clock) begin
      if (reset) begin
         outputSetpoint <= SETPOINT_RESET;
         chargeCurrent <= CHARGE_CURRENT_RESET;
         profileHigh <= PROFILE_HIGH_RESET;
         setupThree <= AUTO_VARIANT ? SETUP_THREE_AUTO_RESET : SETUP_THREE_PLAIN_RESET;
      end else if (regWrite) begin
         if (wAddr == REG_SETUP_ONE) begin
            outputSetpoint <= wData;
         end
         if (wAddr == REG_PROFILE_HIGH) begin
            profileHigh <= wData;
         end
         if (wAddr == REG_SETUP_TWO) begin
            chargeCurrent <= wData;
         end
         if (wAddr == REG_SETUP_THREE) begin
            setupThree <= wData;
            setupThree[SETUP_AUTO_MODE] <= wData[SETUP_AUTO_MODE] & AUTO_VARIANT;
         end
      end
   end

   assign autoModeOn = setupThree[SETUP_AUTO_MODE];

   // Auto cycle tracking; the pulse counts as long until it falls early.
   always_ff @(posedge clock) begin
      if (reset) begin
         autoCycle <= 1'b0;
         autoLong <= 1'b0;
      end else if (autoModeOn && trigRise) begin
         autoCycle <= 1'b1;
         autoLong <= 1'b1;
      end else begin
         if (autoEnd || !modeCommand[CMD_ON_DEMAND] || !autoModeOn) begin
            autoCycle <= 1'b0;
         end
         if (!trigSync && state != ST_ACTIVE) begin
            autoLong <= 1'b0;
         end
      end
   end

   // No-load timer; it restarts whenever load current reappears.
   always_ff @(posedge clock) begin
      if (reset) begin
         nlCount <= '0;
      end else if (autoCycle && !autoLong && state == ST_ACTIVE && senseSync.noLoad) begin
         nlCount <= nlCount + 16'h0001;
      end else begin
         nlCount <= '0;
      end
   end

   assign autoEnd = autoCycle && state == ST_ACTIVE
                 && ((autoLong && !trigSync)
                 || (!autoLong && senseSync.noLoad
                 && nlCount >= 16'(NO_LOAD_COUNT - 1)));

   // Status byte; bit zero is a copy of the ready pin flop.
   assign status = {5'h00, state == ST_ACTIVE, state == ST_CHARGE, readyOut};

   // Read data selection by pointer.
   always_comb begin
      unique case (ptr)
         REG_STATUS: readByte = status;
         REG_PROFILE_HIGH: readByte = profileHigh;
         REG_MODE_COMMAND: readByte = modeCommand;
         REG_SETUP_ONE: readByte = outputSetpoint;
         REG_SETUP_TWO: readByte = chargeCurrent;
         REG_SETUP_THREE: readByte = setupThree;
         default: readByte = ptr < 8'(REG_DEPTH) ? memQ : 8'h00;
      endcase
   end

   bmc_regfile #(
      .WIDTH(8),
      .DEPTH(REG_DEPTH)
   ) scratch (
      .clock(clock),
      .reset(reset),
      .writeEnable(regWrite && wAddr < 8'(REG_DEPTH)),
      .writeAddr(wAddr[$clog2(REG_DEPTH)-1:0]),
      .writeData(wData),
      .readAddr(ptr[$clog2(REG_DEPTH)-1:0]),
      .readData(memQ)
   );

   assign loadNow = sclFall && ((iState == I_ACK && ackPhase && readMode) || iState == I_RD_NEXT);

   // Serial slave; sampling on clock rise, driving on clock fall.
   always_ff @(posedge clock) begin
      if (reset) begin
         iState <= I_IDLE;
         bitCnt <= 3'h0;
         shift <= 8'h00;
         ptr <= 8'h00;
         firstByte <= 1'b0;
         ackPhase <= 1'b0;
         readMode <= 1'b0;
         sdaOeN <= 1'b1;
         regWrite <= 1'b0;
         wAddr <= 8'h00;
         wData <= 8'h00;
      end else begin
         regWrite <= 1'b0;
         if (stopSeen) begin
            iState <= I_IDLE;
            ptr <= 8'h00;
            sdaOeN <= 1'b1;
         end else if (startSeen) begin
            // A repeated start keeps the pointer for the read that follows.
            iState <= I_ADDR;
            bitCnt <= 3'h0;
            firstByte <= 1'b1;
            ackPhase <= 1'b0;
            sdaOeN <= 1'b1;
         end else if (loadNow) begin
            shift <= readByte;
            sdaOeN <= readByte[7];
            bitCnt <= 3'h0;
            ackPhase <= 1'b0;
            iState <= I_RD;
         end else if (sclRise) begin
            unique case (iState)
               I_ADDR, I_WR: begin
                  shift <= {shift[6:0], sdaSync};
                  bitCnt <= bitCnt + 3'h1;
                  if (bitCnt == 3'h7 && iState == I_ADDR) begin
                     iState <= shift[6:0] == myAddr ? I_ACK : I_IDLE;
                     readMode <= sdaSync;
                  end else if (bitCnt == 3'h7) begin
                     iState <= I_ACK;
                     readMode <= 1'b0;
                     firstByte <= 1'b0;
                     if (firstByte) begin
                        ptr <= {shift[6:0], sdaSync};
                     end else begin
                        regWrite <= 1'b1;
                        wAddr <= ptr;
                        wData <= {shift[6:0], sdaSync};
                        ptr <= ptr + 8'h01;
                     end
                  end
               end
               I_RD_ACK: begin
                  ptr <= ptr + 8'h01;
                  iState <= sdaSync ? I_IDLE : I_RD_NEXT;
               end
               I_IDLE, I_ACK, I_RD, I_RD_NEXT: ;
            endcase
         end else if (sclFall) begin
            unique case (iState)
               I_ACK: begin
                  if (!ackPhase) begin
                     sdaOeN <= 1'b0;
                     ackPhase <= 1'b1;
                  end else begin
                     sdaOeN <= 1'b1;
                     ackPhase <= 1'b0;
                     bitCnt <= 3'h0;
                     iState <= I_WR;
                  end
               end
               I_RD: begin
                  if (bitCnt == 3'h7) begin
                     sdaOeN <= 1'b1;
                     iState <= I_RD_ACK;
                  end else begin
                     bitCnt <= bitCnt + 3'h1;
                     shift <= {shift[6:0], 1'b0};
                     sdaOeN <= shift[6];
                  end
               end
               I_IDLE, I_ADDR, I_WR, I_RD_ACK, I_RD_NEXT: ;
            endcase
         end
      end
   end

   // The pin is open drain; only the enable ever moves.
   always_ff @(posedge clock) begin
      sdaOut <= 1'b0;
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   force_active_a: assert property (modeCommand[CMD_FORCE_DRIVE] |=> state == ST_ACTIVE)
      else $error("force drive did not reach active");
   standby_idle_a: assert property (!anyMode |=> state == ST_STANDBY && !drive.chargeEnable
                                    && !drive.driveEnable && !readyOut)
      else $error("no mode bit but not in standby");
   refresh_cap_a: assert property (state == ST_CAP_FULL && senseSync.capBelowTarget
                                   && modeCommand[CMD_CONTINUOUS] && !modeCommand[CMD_FORCE_DRIVE]
                                   |=> state == ST_CHARGE)
      else $error("capacitor refresh missed");
   ready_mirror_a: assert property (status[STATUS_READY] == readyOut)
      else $error("status ready bit differs from pin");
   ready_charge_a: assert property (state == ST_CHARGE && $past(state) == ST_CHARGE |-> !readyOut)
      else $error("ready high while charging");
   trigger_start_a: assert property (autoModeOn && trigRise |=> modeCommand[CMD_ON_DEMAND]
                                     ##1 state == ST_CHARGE || state == ST_ACTIVE)
      else $error("trigger did not start a cycle");
   auto_locked_a: assert property (!AUTO_VARIANT |-> !autoModeOn)
      else $error("auto bit set on plain variant");
   stop_pointer_a: assert property (stopSeen |=> ptr == 8'h00 && iState == I_IDLE)
      else $error("stop did not clear pointer");
   opt_clear_a: assert property (regWrite && wAddr == REG_MODE_COMMAND && wData[CMD_OPT_CLEAR]
                                 |=> drive.optClear ##1 !drive.optClear)
      else $error("optimizer clear strobe wrong");
   long_end_a: assert property (autoCycle && autoLong && state == ST_ACTIVE && !trigSync
                                && !trigRise |=> !modeCommand[CMD_ON_DEMAND])
      else $error("long trigger did not end active");
endmodule

/* pkg/bmc_pkg.sv */
package bmc_pkg;
   // Core clock rate, used to turn times into cycle counts.
   localparam int CLOCK_MHZ = 200;

   // Register offsets.
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_PROFILE_HIGH = 8'h07;
   localparam logic [7:0] REG_MODE_COMMAND = 8'h08;
   localparam logic [7:0] REG_SETUP_ONE = 8'h09;
   localparam logic [7:0] REG_SETUP_TWO = 8'h0a;
   localparam logic [7:0] REG_SETUP_THREE = 8'h0b;

   // Field positions.
   localparam int CMD_ON_DEMAND = 0;
   localparam int CMD_CONTINUOUS = 1;
   localparam int CMD_FORCE_DRIVE = 2;
   localparam int CMD_OPT_CLEAR = 3;
   localparam int SETUP_AUTO_MODE = 7;
   localparam int STATUS_READY = 0;

   // Reset values; the command reset selects optimizer profile 1.
   localparam logic [7:0] CMD_RESET = 8'h10;
   localparam logic [7:0] PROFILE_HIGH_RESET = 8'h00;
   localparam logic [7:0] SETPOINT_RESET = 8'h00;
   localparam logic [7:0] CHARGE_CURRENT_RESET = 8'h00;
   localparam logic [7:0] SETUP_THREE_AUTO_RESET = 8'h80;
   localparam logic [7:0] SETUP_THREE_PLAIN_RESET = 8'h00;

   // Bus slave addresses for the two levels of the select pin.
   localparam logic [6:0] SLAVE_ADDR_LOW = 7'h2e;
   localparam logic [6:0] SLAVE_ADDR_HIGH = 7'h2f;

   // No-load time before an auto cycle with a short trigger ends.
   localparam int NO_LOAD_TIME_US = 10;
   localparam int NO_LOAD_CYCLES = NO_LOAD_TIME_US * CLOCK_MHZ;

   // Scratch register storage depth.
   localparam int REG_DEPTH = 16;

   typedef enum {ST_STANDBY, ST_CHARGE, ST_CAP_FULL, ST_ACTIVE} bmc_state_e;
   typedef enum {I_IDLE, I_ADDR, I_WR, I_ACK, I_RD, I_RD_ACK, I_RD_NEXT} bmc_i2c_e;

   // Comparator results from the converter front end.
   typedef struct packed {
      logic capAtTarget;
      logic capBelowTarget;
      logic outputRegulating;
      logic noLoad;
   } bmc_sense_s;

   // Enables to the converter stages and the optimizer.
   typedef struct packed {
      logic chargeEnable;
      logic driveEnable;
      logic optClear;
   } bmc_drive_s;
endpackage

/* rtl/bmc_regfile.sv */
module bmc_regfile #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic writeEnable,
   input wire logic [$clog2(DEPTH)-1:0] writeAddr,
   input wire logic [WIDTH-1:0] writeData,
   input wire logic [$clog2(DEPTH)-1:0] readAddr,
   output logic [WIDTH-1:0] readData
);
   logic [WIDTH-1:0] store [DEPTH];

   // Storage array; no reset so it maps onto plain memory cells.
   always_ff @(posedge clock) begin
      if (writeEnable) begin
         store[writeAddr] <= writeData;
      end
   end

   // Registered read port.
   always_ff @(posedge clock) begin
      if (reset) begin
         readData <= '0;
      end else begin
         readData <= store[readAddr];
      end
   end
endmodule

/* verification/bmc_host_model.sv */
// Host side of the register port and the trigger pin. The bus lines run on its own timer, so their edges
// keep no fixed phase to the core clock; the trigger pin is set by the testbench 1 ns after a core clock edge.
module bmc_host_model (
   output logic scl,
   output logic sda,
   input wire logic sdaWire,
   output logic triggerIn,
   output logic byteDone,
   output logic [7:0] rdData
);
   timeunit 1ns;
   timeprecision 1ps;
   // A quarter of the 125 ns bus clock period.
   localparam real Q = 31.25;

   // Both bus lines idle released, so the pull-up holds them high.
   initial begin
      scl = 1'b1;
      sda = 1'b1;
      triggerIn = 1'b0;
      byteDone = 1'b0;
      rdData = 8'h00;
   end

   // Data only changes while the bus clock is low; the wire is sampled mid-high.
   task automatic busBit(input logic b, output logic s);
      #Q sda = b;
      #Q scl = 1'b1;
      #Q s = sdaWire;
      #Q scl = 0;
   endtask

   // Also serves as the repeated start when entered with the bus clock low.
   task automatic busStart();
      #Q sda = 1'b1;
      #Q scl = 1'b1;
      #Q sda = 1'b0;
      #Q scl = 1'b0;
   endtask

   task automatic busStop();
      #Q sda = 1'b0;
      #Q scl = 1'b1;
      #Q sda = 1'b1;
      #Q;
   endtask

   // Sends eight bits most significant first, then reads the acknowledge.
   task automatic sendByte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         busBit(b[i], s);
      end
      busBit(1'b1, ack);
   endtask

   // Releases the line for eight bits and answers with ack or nack.
   task automatic recvByte(input logic nack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         busBit(1'b1, d[i]);
      end
      busBit(nack, s);
      rdData = d;
      byteDone = 1'b1;
      #1 byteDone = 1'b0;
   endtask

   task automatic setTrig(input logic v);
      triggerIn = v;
   endtask
endmodule

/* verification/bmc_top_tb_top.sv */
module bmc_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import bmc_pkg::*;
   localparam int NL = 8;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic addrSelect = 1'b0;
   bmc_sense_s sense = '0;
   logic scl, sdaHost, sdaWire, triggerIn, byteDone, sdaOut, sdaOeN, readyOut, autoModeOn;
   logic [7:0] rdData, outputSetpoint, chargeCurrent, profileHigh, modeCommand;
   bmc_drive_s drive;
   logic [7:0] expQ[$];
   int mismatches = 0;
   int n_compared = 0;
   int optCount = 0;
   int seed = 14441;
   logic [7:0] r1, r2, r3, r4;

   // Open-drain data line: low when either side pulls, else the pull-up wins.
   assign sdaWire = sdaHost & (sdaOeN | sdaOut);

   always #2.5 clock = ~clock;

   bmc_top #(.AUTO_VARIANT(1'b1), .NO_LOAD_COUNT(NL)) bmc_top_inst (
      .clock(clock), .reset(reset), .sclIn(scl), .sdaIn(sdaWire), .sdaOut(sdaOut),
      .sdaOeN(sdaOeN), .addrSelect(addrSelect), .triggerIn(triggerIn), .sense(sense),
      .drive(drive), .readyOut(readyOut), .outputSetpoint(outputSetpoint),
      .chargeCurrent(chargeCurrent), .profileHigh(profileHigh),
      .modeCommand(modeCommand), .autoModeOn(autoModeOn)
   );

   bmc_host_model bmc_host_model_inst (
      .scl(scl), .sda(sdaHost), .sdaWire(sdaWire), .triggerIn(triggerIn),
      .byteDone(byteDone), .rdData(rdData)
   );

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (exp !== got) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Each byte the host reads is matched against the oldest queued expectation.
   always @(posedge byteDone) begin
      if (expQ.size() == 0) begin
         chk("readByteUnexpected", 8'hxx, rdData);
      end else begin
         chk("readByte", expQ.pop_front(), rdData);
      end
   end

   // Counts clearing pulses so a missing or extra pulse shows up.
   always @(posedge clock) begin
      if (drive.optClear === 1'b1) begin
         optCount++;
      end
   end

   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   // Sense levels pass two sync flops and one state edge before showing.
   task automatic setSense(input logic [3:0] v, input int n);
      @(posedge clock);
      #1 sense = v;
      settle(n);
   endtask

   task automatic setTrig(input logic v, input int n);
      @(posedge clock);
      #1 bmc_host_model_inst.setTrig(v);
      settle(n);
   endtask

   task automatic wr(input logic [7:0] ptr, input logic [7:0] d[$]);
      logic a;
      bmc_host_model_inst.busStart();
      bmc_host_model_inst.sendByte({SLAVE_ADDR_LOW, 1'b0}, a);
      bmc_host_model_inst.sendByte(ptr, a);
      foreach (d[i]) begin
         bmc_host_model_inst.sendByte(d[i], a);
      end
      bmc_host_model_inst.busStop();
      chk("writeAck", 8'h00, {7'h00, a});
      settle(8);
   endtask

   // Optional pointer write, then a repeated start and n reads, last one nacked.
   task automatic rd(input logic [7:0] ptr, input int n, input logic usePtr);
      logic a;
      logic [7:0] d;
      if (usePtr) begin
         bmc_host_model_inst.busStart();
         bmc_host_model_inst.sendByte({SLAVE_ADDR_LOW, 1'b0}, a);
         bmc_host_model_inst.sendByte(ptr, a);
      end
      bmc_host_model_inst.busStart();
      bmc_host_model_inst.sendByte({SLAVE_ADDR_LOW, 1'b1}, a);
      for (int i = 0; i < n; i++) begin
         bmc_host_model_inst.recvByte(i == n - 1, d);
      end
      bmc_host_model_inst.busStop();
      settle(8);
   endtask

   // A hung handshake is cut short well beyond the expected run time.
   initial begin
      #400us;
      mismatches++;
      final_report();
   end

   initial begin
      logic a;
      int base;
      settle(10);
      reset = 1'b0;
      settle(20);
      chk("modeCommand", CMD_RESET, modeCommand);
      chk("autoModeOn", 8'h01, {7'h00, autoModeOn});
      chk("setpointEtc", 8'h00, outputSetpoint | chargeCurrent | profileHigh);
      chk("idle", 8'h00, {4'h0, drive, readyOut});
      // Every pairing of select pin level and addressed slave.
      // A write probe keeps the slave off the data line, so the stop is seen.
      for (int s = 0; s < 2; s++) begin
         for (int k = 0; k < 2; k++) begin
            @(posedge clock);
            #1 addrSelect = s[0];
            bmc_host_model_inst.busStart();
            bmc_host_model_inst.sendByte({(k == 1) ? SLAVE_ADDR_HIGH : SLAVE_ADDR_LOW, 1'b0}, a);
            bmc_host_model_inst.busStop();
            chk("addrAck", {7'h00, s != k}, {7'h00, a});
         end
      end
      @(posedge clock);
      #1 addrSelect = 1'b0;
      r1 = $random(seed);
      r2 = $random(seed);
      r3 = $random(seed);
      r4 = $random(seed);
      wr(8'h01, '{r1, r2});
      expQ.push_back(8'h00);
      expQ.push_back(r1);
      expQ.push_back(r2);
      rd(8'h00, 3, 1'b0);
      wr(8'h09, '{r3, r4});
      chk("outputSetpoint", r3, outputSetpoint);
      chk("chargeCurrent", r4, chargeCurrent);
      expQ.push_back(r3);
      expQ.push_back(r4);
      rd(8'h09, 2, 1'b1);
      // On-demand: charge first, active at target, ready only when regulating.
      wr(REG_MODE_COMMAND, '{8'h11});
      chk("odCharge", 8'h08, {4'h0, drive, readyOut});
      setSense(4'b1000, 8);
      chk("odActive", 8'h04, {4'h0, drive, readyOut});
      setSense(4'b1010, 8);
      chk("odReady", 8'h05, {4'h0, drive, readyOut});
      expQ.push_back(8'h05);
      rd(REG_STATUS, 1, 1'b1);
      // Straight into continuous while active, no standby between.
      wr(REG_MODE_COMMAND, '{8'h12});
      chk("cmFull", 8'h01, {4'h0, drive, readyOut});
      setSense(4'b0100, 8);
      chk("cmRefresh", 8'h08, {4'h0, drive, readyOut});
      setSense(4'b1000, 8);
      chk("cmReady", 8'h01, {4'h0, drive, readyOut});
      wr(REG_MODE_COMMAND, '{8'h16});
      chk("force", 8'h04, {4'h0, drive, readyOut});
      setSense(4'b0100, 2);
      wr(REG_MODE_COMMAND, '{8'h12});
      chk("recharge", 8'h08, {4'h0, drive, 1'b0});
      wr(REG_MODE_COMMAND, '{8'h10});
      chk("cmStop", 8'h00, {4'h0, drive, readyOut});
      wr(REG_MODE_COMMAND, '{8'h11});
      wr(REG_MODE_COMMAND, '{8'h10});
      chk("odStop", 8'h00, {4'h0, drive, readyOut});
      base = optCount;
      wr(REG_MODE_COMMAND, '{8'h18});
      wr(REG_MODE_COMMAND, '{8'h10});
      chk("optClear", 8'h01, 8'(optCount - base));
      chk("clearBit", 8'h00, {7'h00, modeCommand[CMD_OPT_CLEAR]});
      // Long trigger: the falling pin ends the active state.
      setSense(4'b0000, 2);
      setTrig(1'b1, 8);
      chk("autoStart", 8'h18, {3'h0, modeCommand[0], drive, 1'b0});
      setSense(4'b1010, 8);
      chk("autoReady", 8'h05, {4'h0, drive, readyOut});
      setTrig(1'b0, 8);
      chk("longEnd", 8'h00, {3'h0, modeCommand[0], drive, readyOut});
      // Short trigger: pin drops while charging, then the no-load timer ends it.
      setSense(4'b0000, 2);
      setTrig(1'b1, 2000);
      setTrig(1'b0, 8);
      setSense(4'b1000, 8);
      chk("shortActive", 8'h14, {3'h0, modeCommand[0], drive, readyOut});
      setSense(4'b1001, NL / 2);
      chk("noLoadWait", 8'h01, {7'h00, modeCommand[0]});
      settle(NL + 8);
      chk("noLoadEnd", 8'h00, {3'h0, modeCommand[0], drive, readyOut});
      wr(REG_SETUP_THREE, '{8'h00});
      chk("autoOff", 8'h00, {7'h00, autoModeOn});
      setTrig(1'b1, 8);
      chk("autoIgnored", 8'h00, {7'h00, modeCommand[0]});
      setTrig(1'b0, 2);
      wr(REG_SETUP_THREE, '{8'h80});
      chk("autoOn", 8'h01, {7'h00, autoModeOn});
      chk("expDrained", 8'h00, 8'(expQ.size()));
      final_report();
   end
endmodule
